// *** src/art_cfg.svh ***
// Constants for the auxiliary auto-reload timer control block
`ifndef ART_CFG_SVH
`define ART_CFG_SVH
`define ART_CTRL_ADDR   8'h91
`define ART_CTRL_RESET  8'h00
`define ART_BIT_HOVF    7
`define ART_BIT_LOVF    6
`define ART_BIT_LIRQEN  5
`define ART_BIT_CAPEN   4
`define ART_BIT_SPLIT   3
`define ART_BIT_RUN     2
`define ART_BIT_UNUSED  1
`define ART_BIT_EXTCLK  0
`define ART_SYS_DIV     12
`define ART_EXT_DIV     8
`endif

// *** src/art_pkg.sv ***
// Types shared by the auxiliary auto-reload timer control block
package art_pkg;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } art_sfr_s;
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } art_rld_s;
endpackage

// *** src/art_byte_cnt.sv ***
// One byte of the auto-reload counter
`timescale 1ns/1ps
module art_byte_cnt #(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         tick,
  input  wire logic         reload,
  input  wire logic [W-1:0] reload_val,
  output logic      [W-1:0] cnt_q,
  output logic              wrap
);
  assign wrap = tick & (&cnt_q);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (reload) begin
      cnt_q <= reload_val;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// *** src/art_timer_ctrl.sv ***
// Auxiliary auto-reload timer with control register and capture
// Notes on behaviour
// [RL1] High overflow flag sets when the upper byte rolls over from 0xff and reloads.
// [RL2] Unsplit, high overflow flag sets when the 16-bit count wraps past 0xffff.
// [RL3] High overflow flag requests an interrupt when interrupts are on.
// [RL4] Overflow flags clear only by software writes, never by hardware.
// [RL5] Low overflow flag sets on every low byte wrap, in any mode.
// [RL6] Low overflow interrupts when its enable and interrupts are on.
// [RL7] Capture copies the count into reload on comparator rising edge.
// [RL8] Each capture requests an interrupt when interrupts are enabled.
// [RL9] Split bit 0 gives one 16-bit timer, 1 gives two 8-bit timers.
// [RL10] In 16-bit mode counting happens only while run is set.
// [RL11] In split mode run gates the upper byte; lower byte always counts.
// [RL12] Bit 1 reads as zero and ignores writes.
// [RL13] Clock is core clock over 12, or synchronised external clock over 8.
// [RL14] Split: external select serves both bytes; per-byte selects remain.
// [RL15] Overflow reloads the counter from reload, per byte when split.
// [RL16] Software writes win over simultaneous hardware updates.
`timescale 1ns/1ps
`include "art_cfg.svh"
module art_timer_ctrl (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire art_pkg::art_sfr_s sfr_req,
  output logic           [7:0]   sfr_rdata,
  input  wire art_pkg::art_rld_s reload_wr,
  input  wire logic              timer_irq_en,
  input  wire logic              high_byte_clk_sel,
  input  wire logic              low_byte_clk_sel,
  input  wire logic              ext_clk,
  input  wire logic              analog_compare_out,
  output logic           [7:0]   count_high,
  output logic           [7:0]   count_low,
  output logic           [7:0]   reload_high,
  output logic           [7:0]   reload_low,
  output logic                   irq_req
);
  import art_pkg::*;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic       high_ovf_flag;
  logic       low_ovf_flag;
  logic       low_ovf_irq_en;
  logic       cmp_capture_en;
  logic       split_mode_sel;
  logic       run_ctrl;
  logic       ext_clk_sel;
  logic       ctrl_sel;
  logic       ctrl_wr;
  logic       hi_wrap;
  logic       lo_wrap;
  logic       hovf_set;
  logic       lovf_set;
  logic [7:0] ctrl_d;

  assign high_ovf_flag  = ctrl_q[`ART_BIT_HOVF];
  assign low_ovf_flag   = ctrl_q[`ART_BIT_LOVF];
  assign low_ovf_irq_en = ctrl_q[`ART_BIT_LIRQEN];
  assign cmp_capture_en = ctrl_q[`ART_BIT_CAPEN];
  assign split_mode_sel = ctrl_q[`ART_BIT_SPLIT];
  assign run_ctrl       = ctrl_q[`ART_BIT_RUN];
  assign ext_clk_sel    = ctrl_q[`ART_BIT_EXTCLK];
  assign ctrl_sel       = sfr_req.addr == `ART_CTRL_ADDR;
  assign ctrl_wr        = sfr_req.wr & ctrl_sel;

  // Hardware only ever sets the flags; clearing is software's job
  assign hovf_set = hi_wrap; // RL1 RL2 RL4
  assign lovf_set = lo_wrap; // RL5 RL4

  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d[`ART_BIT_HOVF] = ctrl_q[`ART_BIT_HOVF] | hovf_set;
    ctrl_d[`ART_BIT_LOVF] = ctrl_q[`ART_BIT_LOVF] | lovf_set;
    if (ctrl_wr) begin
      ctrl_d = sfr_req.wdata; // RL16
    end
    ctrl_d[`ART_BIT_UNUSED] = 1'b0; // RL12
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= `ART_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Registered read, one cycle after the address is presented
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= ctrl_sel ? ctrl_q : 8'h00; // RL12
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers for pins
  // ----------------------------------------------------------------
  logic [2:0] ext_sync_q;
  logic [2:0] cmp_sync_q;
  logic       ext_rise;
  logic       cmp_rise;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ext_sync_q <= 3'h0;
      cmp_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clk};
      cmp_sync_q <= {cmp_sync_q[1:0], analog_compare_out};
    end
  end

  // Edge detect looks only past the first stage
  assign ext_rise = ext_sync_q[1] & ~ext_sync_q[2];
  assign cmp_rise = cmp_sync_q[1] & ~cmp_sync_q[2];

  // ----------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------
  localparam logic [3:0] SYS_LAST = 4'(`ART_SYS_DIV - 1);
  localparam logic [2:0] EXT_LAST = 3'(`ART_EXT_DIV - 1);
  logic [3:0] sys_div_q;
  logic [2:0] ext_div_q;
  logic       sys_tick;
  logic       ext_tick;
  logic       base_tick;

  assign sys_tick = sys_div_q == SYS_LAST;
  assign ext_tick = ext_rise & (ext_div_q == EXT_LAST);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sys_div_q <= 4'h0;
      ext_div_q <= 3'h0;
    end else begin
      sys_div_q <= sys_tick ? 4'h0 : sys_div_q + 4'h1; // RL13
      if (ext_rise) begin
        ext_div_q <= ext_div_q + 3'h1; // RL13
      end
    end
  end

  // Synchronising costs up to three core cycles of external-clock skew
  assign base_tick = ext_clk_sel ? ext_tick : sys_tick; // RL13 RL14

  // ----------------------------------------------------------------
  // Counter bytes and reload
  // ----------------------------------------------------------------
  logic       lo_src;
  logic       hi_src;
  logic       lo_tick;
  logic       hi_tick;
  logic       lo_reload;
  logic       hi_reload;
  logic       capture;
  logic [7:0] rld_hi_q;
  logic [7:0] rld_lo_q;

  assign lo_src = low_byte_clk_sel | base_tick; // RL14
  assign hi_src = high_byte_clk_sel | base_tick; // RL14
  // Unsplit, the low byte select clocks the whole 16-bit count
  assign lo_tick = split_mode_sel ? lo_src : (run_ctrl & lo_src); // RL10 RL11
  assign hi_tick = split_mode_sel ? (run_ctrl & hi_src) : lo_wrap; // RL9 RL11
  assign lo_reload = split_mode_sel ? lo_wrap : hi_wrap; // RL15 RL9
  assign hi_reload = hi_wrap; // RL15

  art_byte_cnt #(.W(8)) u_lo (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .tick       (lo_tick),
    .reload     (lo_reload),
    .reload_val (rld_lo_q),
    .cnt_q      (count_low),
    .wrap       (lo_wrap)
  );

  art_byte_cnt #(.W(8)) u_hi (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .tick       (hi_tick),
    .reload     (hi_reload),
    .reload_val (rld_hi_q),
    .cnt_q      (count_high),
    .wrap       (hi_wrap)
  );

  assign capture = cmp_capture_en & cmp_rise; // RL7

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rld_hi_q <= 8'h00;
      rld_lo_q <= 8'h00;
    end else if (reload_wr.wr) begin
      {rld_hi_q, rld_lo_q} <= reload_wr.data; // RL16
    end else if (capture) begin
      {rld_hi_q, rld_lo_q} <= {count_high, count_low}; // RL7
    end
  end

  assign reload_high = rld_hi_q;
  assign reload_low  = rld_lo_q;

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  logic cap_evt_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cap_evt_q <= 1'b0;
    end else begin
      cap_evt_q <= capture; // RL8
    end
  end

  assign irq_req = timer_irq_en & (high_ovf_flag // RL3
                 | (low_ovf_irq_en & low_ovf_flag) // RL6
                 | cap_evt_q); // RL8

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence hi_ovf_s;
    !ctrl_wr && hi_wrap;
  endsequence

  hi_flag_set_a: assert property (hi_ovf_s |=> high_ovf_flag) // RL1
    else $error("high flag not set on wrap");
  lo_flag_set_a: assert property (!ctrl_wr && lo_wrap |=> low_ovf_flag) // RL5
    else $error("low flag not set on wrap");
  flag_hold_a: assert property (!ctrl_wr && high_ovf_flag |=> // RL4
    high_ovf_flag)
    else $error("high flag cleared by hardware");
  unused_zero_a: assert property (sfr_rdata[`ART_BIT_UNUSED] == 1'b0) // RL12
    else $error("unused bit read nonzero");
  run_hold_a: assert property (!split_mode_sel && !run_ctrl |=> // RL10
    $stable(count_low) || $past(lo_reload))
    else $error("count moved while stopped");
  split_lo_a: assert property (split_mode_sel && low_byte_clk_sel && // RL11
    !lo_wrap |=> count_low == $past(count_low) + 8'h01)
    else $error("low byte not counting in split");
  wrap16_reload_a: assert property (!split_mode_sel && hi_wrap |=> // RL15
    {count_high, count_low} == $past({rld_hi_q, rld_lo_q}))
    else $error("no 16-bit reload");
  capture_a: assert property (capture && !reload_wr.wr |=> // RL7
    {rld_hi_q, rld_lo_q} == $past({count_high, count_low}))
    else $error("capture missed");
  sw_reload_a: assert property (reload_wr.wr |=> // RL16
    {rld_hi_q, rld_lo_q} == $past(reload_wr.data))
    else $error("software reload lost");
  cap_irq_a: assert property (capture && timer_irq_en ##1 timer_irq_en // RL8
    |-> irq_req)
    else $error("no capture interrupt");
  hi_irq_a: assert property (high_ovf_flag && timer_irq_en |-> irq_req) // RL3
    else $error("no overflow interrupt");
  sys_div_a: assert property (!ext_clk_sel && sys_tick |=> // RL13
    !sys_tick[*8] ##1 !sys_tick[*3] ##1 sys_tick)
    else $error("core divider period wrong");
endmodule

// *** testbench/art_timer_ctrl_tb.sv ***
// Self-checking bench for the auxiliary auto-reload timer control
`timescale 1ns/1ps
module art_timer_ctrl_tb;
  import art_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset   = 1'b1;
  art_sfr_s    req     = '0;
  art_rld_s    rld     = '0;
  logic        ie      = 1'b0;
  logic        hsel    = 1'b0;
  logic        lsel    = 1'b0;
  logic        ext_clk = 1'b0;
  logic        cmp     = 1'b0;
  logic        ext_run = 1'b0;
  logic        seen    = 1'b0;
  logic [7:0]  rdata, ch, cl, rh, rlo, d, c0;
  logic        irq;
  logic [15:0] rl, h16;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          seed      = 32'he2bd;
  int          i;
  wire  [15:0] cnt = {ch, cl};

  art_timer_ctrl dut (
    .sys_clk(sys_clk), .reset(reset), .sfr_req(req), .sfr_rdata(rdata),
    .reload_wr(rld), .timer_irq_en(ie), .high_byte_clk_sel(hsel),
    .low_byte_clk_sel(lsel), .ext_clk(ext_clk), .analog_compare_out(cmp),
    .count_high(ch), .count_low(cl), .reload_high(rh), .reload_low(rlo),
    .irq_req(irq));

  always #2.5 sys_clk = ~sys_clk;
  // Ext pin toggles every cycle: one rising edge per two core clocks
  always @(posedge sys_clk) begin
    if (ext_run) ext_clk <= ~ext_clk;
    if (irq === 1'b1) seen <= 1'b1;
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // Bit 1 always reads back as zero
  function automatic logic [7:0] exp_ctrl(input logic [7:0] v);
    return v & 8'hfd;
  endfunction
  task automatic step(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    tests_run++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge sys_clk) req <= '{1'b1, a, v};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk) req <= '{1'b0, a, 8'h00};
    step(2);
    d = rdata;
  endtask
  task automatic rlw(input logic [15:0] v);
    @(posedge sys_clk) rld <= '{1'b1, v};
    @(posedge sys_clk) rld.wr <= 1'b0;
    step(1);
    chk("reload", v, {rh, rlo});
  endtask
  // Bounded wait, always at least one edge so a one-cycle value is caught
  task automatic wt(input logic [15:0] m, v);
    i = 0;
    do step(1); while (++i < 70000 && (cnt & m) !== v);
    chk("wait", v, cnt & m);
  endtask
  task automatic meas(input int n, input logic [7:0] e);
    step(1);
    c0 = cl;
    i = 0;
    do step(1); while (++i < 100 && cl === c0);
    c0 = cl;
    step(n);
    chk("rate", {8'h00, e}, {8'h00, cl - c0});
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #450000;
    error_cnt++;
    conclude;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h91);
    chk("ctrl_rst", 16'h0000, {8'h00, d});
    // Run and split kept clear so nothing counts here
    for (int k = 0; k < 8; k++) begin
      c0 = 8'($random(seed)) & 8'hf3;
      @(posedge sys_clk) ie <= 1'($random(seed));
      wr(8'h91, c0);
      rd(8'h91);
      chk("ctrl_rw", {8'h00, exp_ctrl(c0)}, {8'h00, d});
      chk("irq", {15'h0, ie & (c0[7] | c0[6] & c0[5])}, {15'h0, irq});
    end
    wr(8'h91, 8'h00);
    wr(8'h92, 8'hff);
    rd(8'h92);
    chk("unmapped", 16'h0000, {8'h00, d});
    rd(8'h91);
    chk("ctrl_keep", 16'h0000, {8'h00, d});
    $display("test registers done");
    rl = 16'($random(seed));
    rlw(rl);
    @(posedge sys_clk) lsel <= 1'b1;
    @(posedge sys_clk) ie <= 1'b1;
    wr(8'h91, 8'h04);
    wt(16'hffff, 16'hffff);
    step(1);
    chk("wrap16", rl, cnt);
    rd(8'h91);
    chk("flags16", 16'h00c4, {8'h00, d});
    chk("irq_h", 16'h0001, {15'h0, irq});
    wr(8'h91, 8'h00);
    step(1);
    h16 = cnt;
    step(20);
    chk("hold", h16, cnt);
    rd(8'h91);
    chk("flag_clr", 16'h0000, {8'h00, d});
    $display("test wrap16 done");
    wr(8'h91, 8'h08);
    wt(16'h00ff, 16'h00ff);
    step(1);
    chk("low_rld", {8'h00, rl[7:0]}, {8'h00, cl});
    chk("high_held", {8'h00, h16[15:8]}, {8'h00, ch});
    rd(8'h91);
    chk("lflag", 16'h0048, {8'h00, d});
    chk("irq_off", 16'h0000, {15'h0, irq});
    wr(8'h91, 8'h28);
    wt(16'h00ff, 16'h00ff);
    step(1);
    chk("irq_low", 16'h0001, {15'h0, irq});
    @(posedge sys_clk) hsel <= 1'b1;
    wr(8'h91, 8'h0c);
    wt(16'hff00, 16'hff00);
    step(1);
    chk("high_rld", {8'h00, rl[15:8]}, {8'h00, ch});
    rd(8'h91);
    chk("hflag", 16'h0080, {8'h00, d & 8'h80});
    $display("test split done");
    // Count held still so the captured value is known
    wr(8'h91, 8'h10);
    step(2);
    seen = 1'b0;
    @(posedge sys_clk) cmp <= 1'b1;
    step(8);
    chk("capture", cnt, {rh, rlo});
    chk("cap_irq", 16'h0001, {15'h0, seen});
    @(posedge sys_clk) cmp <= 1'b0;
    $display("test capture done");
    rlw(16'h0000);
    @(posedge sys_clk) lsel <= 1'b0;
    wr(8'h91, 8'h08);
    meas(126, 8'h0a);
    @(posedge sys_clk) ext_run <= 1'b1;
    wr(8'h91, 8'h09);
    meas(88, 8'h05);
    $display("test clock done");
    conclude;
  end
endmodule
